// File: rtl/ascu_defs.svh
// Constants of the analyzer serial command unit: offsets, fields, resets
// Assumes a 10 MHz system clock and byte-wide serial streams on the same clock
`ifndef ASCU_DEFS_SVH
`define ASCU_DEFS_SVH

// Register byte offsets
`define ASCU_OFF_CTRL 8'h00
`define ASCU_OFF_FAULT 8'h04
`define ASCU_OFF_GAS_HI 8'h08
`define ASCU_OFF_GAS_LO 8'h0C
`define ASCU_OFF_STATUS 8'h10
`define ASCU_OFF_PFTIME 8'h14
`define ASCU_OFF_OVR_EN 8'h18
`define ASCU_OFF_RANGE0 8'h1C
`define ASCU_OFF_RANGE1 8'h20
`define ASCU_OFF_RANGE2 8'h24

// Control register fields
`define ASCU_CTRL_PROTO1 1:0
`define ASCU_CTRL_PROTO2 3:2
`define ASCU_CTRL_PPM 4
`define ASCU_CTRL_OOS 5
`define ASCU_CTRL_DEV_ID 17:8
`define ASCU_CTRL_RST 32'h0000_0010

// Range register fields: normal full scale low, over-range value high
`define ASCU_RANGE_NORM 15:0
`define ASCU_RANGE_OVR 31:16
`define ASCU_RANGE_RST 32'h0000_0000

// Protocol characters and limits
`define ASCU_CH_STX 8'h02
`define ASCU_CH_ETX 8'h03
`define ASCU_CH_ACK 8'h06
`define ASCU_CH_NAK 8'h15
`define ASCU_CH_CR 8'h0D
`define ASCU_CH_LF 8'h0A
`define ASCU_CH_SP 8'h20
`define ASCU_CH_COMMA 8'h2C
`define ASCU_CH_ZERO 8'h30
`define ASCU_CH_NINE 8'h39
`define ASCU_TEXT_MAX 7'h78
`define ASCU_BCC_INIT 8'h00
`define ASCU_ID_DIGITS 2'h3
`define ASCU_CONC_LEN 4'hF

// Legacy command words
`define ASCU_CMD_CONC 40'h44434F4E43
`define ASCU_CMD_SPAN 40'h445350414E
`define ASCU_CMD_ZERO 40'h445A45524F
`define ASCU_CMD_ABORT "ABORT"
`define ASCU_CMD_RESET "RESET"

`endif

// File: rtl/ascu_pkg.sv
// Types of the analyzer serial command unit
// Assumes ascu_defs.svh for all numeric constants
package ascu_pkg;

  // Per-port protocol selector
  typedef enum logic [1:0] {
    ASCU_PROTO_LEGACY = 2'h0,
    ASCU_PROTO_FRAMED = 2'h1,
    ASCU_PROTO_ADV = 2'h2
  } ascu_proto_e;

  // Operating mode
  typedef enum logic [1:0] {
    ASCU_MODE_MEASURE = 2'h0,
    ASCU_MODE_ZERO = 2'h1,
    ASCU_MODE_SPAN = 2'h2
  } ascu_mode_e;

  // Receive and reply state
  typedef enum logic [2:0] {
    ASCU_ST_CMD = 3'h0,
    ASCU_ST_ID = 3'h1,
    ASCU_ST_TEXT = 3'h2,
    ASCU_ST_CK1 = 3'h3,
    ASCU_ST_CK2 = 3'h4,
    ASCU_ST_TX = 3'h5
  } ascu_state_e;

  // Power-fail time stamp, packed as stored
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] date;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } ascu_stamp_s;

  // Instrument status word
  typedef struct packed {
    logic [9:0] faults;
    logic out_of_service;
    logic zero_mode;
    logic span_mode;
    logic unused;
    logic ppm_units;
    logic reserved;
  } ascu_status_s;

endpackage

// File: rtl/ascu_core.sv
// Analyzer serial command unit: legacy command interpreter and framed message checker with
// Wishbone classic register slave
// Assumes rx and tx byte streams are on clk_i (UART outside this block)
//
// Summary of operation
// [RQ1] Framed message opens with byte 02h
// [RQ2] Text closes with 03h, check chars follow
// [RQ3] Framed text body at most 120 characters
// [RQ4] Check is XOR from start through end
// [RQ5] Check sent as two hex characters, high first
// [RQ6] Host pads identifier to three decimal digits
// [RQ7] Concentration query replies gas, space, status, CRLF
// [RQ8] Legacy numeric values use floating point text
// [RQ9] Status bits 15..6 carry ten fault flags
// [RQ10] Bits 5,4,3: out-of-service, zero, span
// [RQ11] Bit1 ppm units; bit2 unused, bit0 reserved
// [RQ12] Span command enters span mode, ACK/NAK
// [RQ13] Zero command enters zero mode, ACK/NAK
// [RQ14] Abort returns to measure mode, ACK/NAK
// [RQ15] Reset command acknowledges, then reboots
// [RQ16] Each port has own protocol selector
// [RQ17] Power-fail time packed into 32-bit word
// [RQ18] Per-output over-ranging enable bit
// [RQ19] Over-ranging uses the held upper range
// [RQ20] Bad check or overlong frame is discarded
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ascu_defs.svh"

module ascu_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial port 1 byte stream
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // Power-fail capture
  input wire logic pf_strobe_i,
  input wire ascu_pkg::ascu_stamp_s pf_stamp_i,
  // Instrument side
  output ascu_pkg::ascu_proto_e proto2_o,
  output ascu_pkg::ascu_mode_e mode_o,
  output logic [47:0] full_scale_o,
  output logic reboot_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    wmask = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [9:0] fault_reg, fault_next;
  logic [31:0] gas_hi_reg, gas_hi_next;
  logic [31:0] gas_lo_reg, gas_lo_next;
  ascu_pkg::ascu_stamp_s stamp_reg, stamp_next;
  logic [2:0] ovr_en_reg, ovr_en_next;
  logic [31:0] range_reg [3];
  logic [31:0] range_next [3];
  logic [47:0] fs_reg, fs_next;
  ascu_pkg::ascu_mode_e mode_reg, mode_next;
  ascu_pkg::ascu_state_e st_reg, st_next;
  logic [39:0] cmd_reg, cmd_next;
  logic [9:0] idv_reg, idv_next;
  logic [1:0] idn_reg, idn_next;
  logic [7:0] bcc_reg, bcc_next;
  logic [6:0] len_reg, len_next;
  logic ovf_reg, ovf_next;
  logic ck_ok_reg, ck_ok_next;
  logic [7:0] good_reg, good_next;
  logic [7:0] bad_reg, bad_next;
  logic [7:0] buf_reg [15];
  logic [7:0] buf_next [15];
  logic [3:0] idx_reg, idx_next;
  logic [3:0] blen_reg, blen_next;
  logic [7:0] txd_reg, txd_next;
  logic txv_reg, txv_next;
  logic reb_pend_reg, reb_pend_next;
  logic reboot_reg, reboot_next;

  ascu_pkg::ascu_status_s status;
  ascu_pkg::ascu_proto_e proto1;
  logic bus_req;
  logic id_match;
  logic comply;
  logic [7:0] rxb;

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly

  always_comb begin
    status.faults = fault_reg; // see [RQ9]
    status.out_of_service = ctrl_reg[`ASCU_CTRL_OOS]; // see [RQ10]
    status.zero_mode = (mode_reg == ascu_pkg::ASCU_MODE_ZERO); // see [RQ10]
    status.span_mode = (mode_reg == ascu_pkg::ASCU_MODE_SPAN); // see [RQ10]
    status.unused = 1'b0; // see [RQ11]
    status.ppm_units = ctrl_reg[`ASCU_CTRL_PPM]; // see [RQ11]
    status.reserved = 1'b0; // see [RQ11]
  end

  assign proto1 = ascu_pkg::ascu_proto_e'(ctrl_reg[`ASCU_CTRL_PROTO1]); // see [RQ16]
  assign bus_req = cyc_i & stb_i & ~ack_reg;
  assign rxb = rx_data_i;
  // No digits means an unaddressed command; otherwise all three must match
  assign id_match = (idn_reg == 2'h0) ||
                    ((idn_reg == `ASCU_ID_DIGITS) && (idv_reg == ctrl_reg[`ASCU_CTRL_DEV_ID])); // see [RQ6]
  assign comply = ~ctrl_reg[`ASCU_CTRL_OOS];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    ack_next = bus_req;
    dat_next = dat_reg;
    ctrl_next = ctrl_reg;
    fault_next = fault_reg;
    gas_hi_next = gas_hi_reg;
    gas_lo_next = gas_lo_reg;
    stamp_next = stamp_reg;
    ovr_en_next = ovr_en_reg;
    range_next = range_reg;
    mode_next = mode_reg;
    st_next = st_reg;
    cmd_next = cmd_reg;
    idv_next = idv_reg;
    idn_next = idn_reg;
    bcc_next = bcc_reg;
    len_next = len_reg;
    ovf_next = ovf_reg;
    ck_ok_next = ck_ok_reg;
    good_next = good_reg;
    bad_next = bad_reg;
    buf_next = buf_reg;
    idx_next = idx_reg;
    blen_next = blen_reg;
    txd_next = txd_reg;
    txv_next = txv_reg;
    reb_pend_next = reb_pend_reg;
    reboot_next = 1'b0;

    // Register bus
    if (bus_req && we_i) begin
      if (adr_i == `ASCU_OFF_CTRL) begin
        ctrl_next = wmask(ctrl_reg, dat_i, sel_i); // see [RQ16]
      end else if (adr_i == `ASCU_OFF_FAULT) begin
        fault_next = 10'(wmask({22'h0, fault_reg}, dat_i, sel_i));
      end else if (adr_i == `ASCU_OFF_GAS_HI) begin
        gas_hi_next = wmask(gas_hi_reg, dat_i, sel_i);
      end else if (adr_i == `ASCU_OFF_GAS_LO) begin
        gas_lo_next = wmask(gas_lo_reg, dat_i, sel_i);
      end else if (adr_i == `ASCU_OFF_PFTIME) begin
        stamp_next = wmask(stamp_reg, dat_i, sel_i); // see [RQ17]
      end else if (adr_i == `ASCU_OFF_OVR_EN) begin
        ovr_en_next = 3'(wmask({29'h0, ovr_en_reg}, dat_i, sel_i)); // see [RQ18]
      end else if (adr_i == `ASCU_OFF_RANGE0) begin
        range_next[0] = wmask(range_reg[0], dat_i, sel_i);
      end else if (adr_i == `ASCU_OFF_RANGE1) begin
        range_next[1] = wmask(range_reg[1], dat_i, sel_i);
      end else if (adr_i == `ASCU_OFF_RANGE2) begin
        range_next[2] = wmask(range_reg[2], dat_i, sel_i);
      end
    end else if (bus_req) begin
      if (adr_i == `ASCU_OFF_CTRL) begin
        dat_next = ctrl_reg;
      end else if (adr_i == `ASCU_OFF_FAULT) begin
        dat_next = {22'h0, fault_reg};
      end else if (adr_i == `ASCU_OFF_GAS_HI) begin
        dat_next = gas_hi_reg;
      end else if (adr_i == `ASCU_OFF_GAS_LO) begin
        dat_next = gas_lo_reg;
      end else if (adr_i == `ASCU_OFF_STATUS) begin
        dat_next = {bad_reg, good_reg, status};
      end else if (adr_i == `ASCU_OFF_PFTIME) begin
        dat_next = stamp_reg; // see [RQ17]
      end else if (adr_i == `ASCU_OFF_OVR_EN) begin
        dat_next = {29'h0, ovr_en_reg};
      end else if (adr_i == `ASCU_OFF_RANGE0) begin
        dat_next = range_reg[0];
      end else if (adr_i == `ASCU_OFF_RANGE1) begin
        dat_next = range_reg[1];
      end else if (adr_i == `ASCU_OFF_RANGE2) begin
        dat_next = range_reg[2];
      end else begin
        dat_next = 32'h0000_0000;
      end
    end

    // A power fail capture wins over a software write in the same cycle
    if (pf_strobe_i) begin
      stamp_next = pf_stamp_i; // see [RQ17]
    end

    // Reply transmitter
    if (st_reg == ascu_pkg::ASCU_ST_TX) begin
      if (txv_reg && tx_ready_i) begin
        if (idx_reg == blen_reg - 4'h1) begin
          txv_next = 1'b0;
          st_next = ascu_pkg::ASCU_ST_CMD;
          if (reb_pend_reg) begin
            reboot_next = 1'b1; // see [RQ15]
            reb_pend_next = 1'b0;
          end
        end else begin
          idx_next = idx_reg + 4'h1;
          txd_next = buf_reg[idx_reg + 4'h1];
        end
      end
    end else if (rx_valid_i && proto1 == ascu_pkg::ASCU_PROTO_LEGACY) begin
      case (st_reg)
        ascu_pkg::ASCU_ST_ID: begin
          if (rxb >= `ASCU_CH_ZERO && rxb <= `ASCU_CH_NINE) begin
            idv_next = 10'(idv_reg * 10'd10 + {6'h0, rxb[3:0]}); // see [RQ6]
            if (idn_reg != 2'h3) begin
              idn_next = idn_reg + 2'h1;
            end
          end else if (rxb == `ASCU_CH_CR) begin
            st_next = ascu_pkg::ASCU_ST_CMD;
            cmd_next = 40'h0;
            blen_next = 4'h1;
            if (!id_match) begin
              blen_next = 4'h0;
            end else if (cmd_reg == `ASCU_CMD_CONC) begin
              // Gas text is floating point text written by software
              for (int i = 0; i < 4; i++) begin
                buf_next[i] = gas_hi_reg[31 - 8*i -: 8]; // see [RQ8]
                buf_next[i + 4] = gas_lo_reg[31 - 8*i -: 8]; // see [RQ8]
              end
              buf_next[8] = `ASCU_CH_SP; // see [RQ7]
              for (int i = 0; i < 4; i++) begin
                buf_next[9 + i] = hex_char(status[15 - 4*i -: 4]); // see [RQ7]
              end
              buf_next[13] = `ASCU_CH_CR; // see [RQ7]
              buf_next[14] = `ASCU_CH_LF; // see [RQ7]
              blen_next = `ASCU_CONC_LEN;
            end else if (cmd_reg == `ASCU_CMD_SPAN) begin
              buf_next[0] = comply ? `ASCU_CH_ACK : `ASCU_CH_NAK; // see [RQ12]
              if (comply) begin
                mode_next = ascu_pkg::ASCU_MODE_SPAN; // see [RQ12]
              end
            end else if (cmd_reg == `ASCU_CMD_ZERO) begin
              buf_next[0] = comply ? `ASCU_CH_ACK : `ASCU_CH_NAK; // see [RQ13]
              if (comply) begin
                mode_next = ascu_pkg::ASCU_MODE_ZERO; // see [RQ13]
              end
            end else if (cmd_reg == `ASCU_CMD_ABORT) begin
              // Returning to measure is always possible
              buf_next[0] = `ASCU_CH_ACK; // see [RQ14]
              mode_next = ascu_pkg::ASCU_MODE_MEASURE; // see [RQ14]
            end else if (cmd_reg == `ASCU_CMD_RESET) begin
              buf_next[0] = `ASCU_CH_ACK; // see [RQ15]
              reb_pend_next = 1'b1; // see [RQ15]
            end else begin
              blen_next = 4'h0;
            end
            if (blen_next != 4'h0) begin
              st_next = ascu_pkg::ASCU_ST_TX;
              idx_next = 4'h0;
              txd_next = buf_next[0];
              txv_next = 1'b1;
            end
          end
        end
        default: begin
          if (rxb == `ASCU_CH_COMMA) begin
            st_next = ascu_pkg::ASCU_ST_ID;
            idv_next = 10'h0;
            idn_next = 2'h0;
          end else if (rxb == `ASCU_CH_CR || rxb == `ASCU_CH_LF) begin
            cmd_next = 40'h0;
          end else begin
            cmd_next = {cmd_reg[31:0], rxb};
          end
        end
      endcase
    end else if (rx_valid_i && proto1 == ascu_pkg::ASCU_PROTO_FRAMED) begin
      // A start byte always restarts framing
      if (rxb == `ASCU_CH_STX) begin
        st_next = ascu_pkg::ASCU_ST_TEXT; // see [RQ1]
        bcc_next = `ASCU_BCC_INIT ^ rxb; // see [RQ4]
        len_next = 7'h0;
        ovf_next = 1'b0;
      end else begin
        case (st_reg)
          ascu_pkg::ASCU_ST_TEXT: begin
            bcc_next = bcc_reg ^ rxb; // see [RQ4]
            if (rxb == `ASCU_CH_ETX) begin
              st_next = ascu_pkg::ASCU_ST_CK1; // see [RQ2]
            end else if (len_reg == `ASCU_TEXT_MAX) begin
              ovf_next = 1'b1; // see [RQ3]
            end else begin
              len_next = len_reg + 7'h1;
            end
          end
          ascu_pkg::ASCU_ST_CK1: begin
            ck_ok_next = (rxb == hex_char(bcc_reg[7:4])); // see [RQ5]
            st_next = ascu_pkg::ASCU_ST_CK2;
          end
          ascu_pkg::ASCU_ST_CK2: begin
            st_next = ascu_pkg::ASCU_ST_CMD;
            if (ck_ok_reg && rxb == hex_char(bcc_reg[3:0]) && !ovf_reg) begin
              good_next = good_reg + 8'h1; // see [RQ5]
            end else begin
              bad_next = bad_reg + 8'h1; // see [RQ20]
            end
          end
          default: begin
            st_next = ascu_pkg::ASCU_ST_CMD;
          end
        endcase
      end
    end

    // Full scale per analog output
    for (int i = 0; i < 3; i++) begin
      fs_next[i*16 +: 16] = ovr_en_reg[i] ? range_reg[i][`ASCU_RANGE_OVR]
                                          : range_reg[i][`ASCU_RANGE_NORM]; // see [RQ19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      ctrl_reg <= `ASCU_CTRL_RST;
      fault_reg <= 10'h000;
      gas_hi_reg <= 32'h0000_0000;
      gas_lo_reg <= 32'h0000_0000;
      stamp_reg <= 32'h0000_0000;
      ovr_en_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        range_reg[i] <= `ASCU_RANGE_RST;
      end
      fs_reg <= 48'h0;
      mode_reg <= ascu_pkg::ASCU_MODE_MEASURE;
      st_reg <= ascu_pkg::ASCU_ST_CMD;
      cmd_reg <= 40'h0;
      idv_reg <= 10'h0;
      idn_reg <= 2'h0;
      bcc_reg <= `ASCU_BCC_INIT;
      len_reg <= 7'h0;
      ovf_reg <= 1'b0;
      ck_ok_reg <= 1'b0;
      good_reg <= 8'h00;
      bad_reg <= 8'h00;
      for (int i = 0; i < 15; i++) begin
        buf_reg[i] <= 8'h00;
      end
      idx_reg <= 4'h0;
      blen_reg <= 4'h0;
      txd_reg <= 8'h00;
      txv_reg <= 1'b0;
      reb_pend_reg <= 1'b0;
      reboot_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      ctrl_reg <= ctrl_next;
      fault_reg <= fault_next;
      gas_hi_reg <= gas_hi_next;
      gas_lo_reg <= gas_lo_next;
      stamp_reg <= stamp_next;
      ovr_en_reg <= ovr_en_next;
      range_reg <= range_next;
      fs_reg <= fs_next;
      mode_reg <= mode_next;
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      idv_reg <= idv_next;
      idn_reg <= idn_next;
      bcc_reg <= bcc_next;
      len_reg <= len_next;
      ovf_reg <= ovf_next;
      ck_ok_reg <= ck_ok_next;
      good_reg <= good_next;
      bad_reg <= bad_next;
      buf_reg <= buf_next;
      idx_reg <= idx_next;
      blen_reg <= blen_next;
      txd_reg <= txd_next;
      txv_reg <= txv_next;
      reb_pend_reg <= reb_pend_next;
      reboot_reg <= reboot_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign tx_data_o = txd_reg;
  assign tx_valid_o = txv_reg;
  assign proto2_o = ascu_pkg::ascu_proto_e'(ctrl_reg[`ASCU_CTRL_PROTO2]); // see [RQ16]
  assign mode_o = mode_reg;
  assign full_scale_o = fs_reg;
  assign reboot_o = reboot_reg;

endmodule

`default_nettype wire

// File: test/ascu_core_props.sv
// Port checker of the serial command unit
// Assumes ascu_core ports on one clock with synchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "ascu_defs.svh"
module ascu_core_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Reply stream
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  // Instrument side
  input wire ascu_pkg::ascu_mode_e mode_o,
  input wire logic reboot_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_next:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("bus ack late");
  chk_ack_single:
    assert property (ack_o |=> !ack_o) else $error("bus ack too long");
  chk_tx_hold:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("reply byte lost");
  chk_reboot_pulse:
    assert property (reboot_o |=> !reboot_o) else $error("reboot pulse too long");
  chk_reboot_after:
    assert property ($rose(reboot_o) |-> $past(tx_valid_o && tx_ready_i && tx_data_o == `ASCU_CH_ACK))
      else $error("reboot without ack");
  chk_mode_legal:
    assert property (mode_o != 2'h3) else $error("illegal mode");
  chk_mode_ack:
    assert property (!$past(rst_i) && mode_o != $past(mode_o) |-> tx_valid_o && tx_data_o == `ASCU_CH_ACK)
      else $error("mode change without ack");
  chk_reset_quiet:
    assert property ($fell(rst_i) |-> !ack_o && !tx_valid_o && !reboot_o && mode_o == ascu_pkg::ASCU_MODE_MEASURE)
      else $error("outputs not cleared by reset");
endmodule
bind ascu_core ascu_core_props u_ascu_core_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .mode_o(mode_o),
  .reboot_o(reboot_o));
`default_nettype wire

// File: test/ascu_host.sv
// Host model on serial port 1: sends commands and frames, collects replies
// Assumes byte streams on the system clock
`timescale 1ns/10ps
`default_nettype none
module ascu_host (
  // Clock
  input wire logic clk_i,
  // Byte streams
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] got[$];
  logic slow;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
    slow = 1'b0;
  end
  // Slow mode stalls every other cycle
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  end
  // Data line shows the inverse of the last byte outside a valid pulse
  task automatic put(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b;
  endtask
  // Identifier always given as three padded digits by the caller
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      put(s[i]);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  // Start, text, end, check high then low; flip spoils the check
  task automatic frame(input string t, input logic [7:0] flip);
    logic [7:0] c;
    c = 8'h02 ^ 8'h03 ^ flip;
    for (int i = 0; i < t.len(); i++) begin
      c = c ^ t[i];
    end
    put(8'h02);
    send(t);
    put(8'h03);
    put(hx(c[7:4]));
    put(hx(c[3:0]));
  endtask
endmodule
`default_nettype wire

// File: test/analyzer_serial_command_unit_tb_top.sv
// Testbench of the serial command unit: register bus and host command sequences
// Assumes ascu_core, ascu_host and the checker bound to the core
`timescale 1ns/10ps
`default_nettype none
`include "ascu_defs.svh"
module analyzer_serial_command_unit_tb_top;
  logic clk, rst, we, cyc, stb, ack, rx_valid, tx_valid, tx_ready, pf_strobe, reboot;
  logic [7:0] adr, rx_data, tx_data;
  logic [31:0] wdat, rdat, q;
  logic [47:0] fs;
  ascu_pkg::ascu_stamp_s pf_stamp;
  ascu_pkg::ascu_proto_e proto2;
  ascu_pkg::ascu_mode_e mode;
  int error_cnt = 0;
  int num_checks = 0;
  int reboots = 0;
  string s;
  ascu_core u_ascu_core (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat), .sel_i(4'hF), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .pf_strobe_i(pf_strobe),
    .pf_stamp_i(pf_stamp), .proto2_o(proto2), .mode_o(mode), .full_scale_o(fs), .reboot_o(reboot));
  ascu_host u_ascu_host (.clk_i(clk), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reboot === 1'b1) begin
      reboots++;
    end
  end
  initial begin
    #5ms;
    error_cnt++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("TB: checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Waits for the expected reply length, then makes sure nothing more follows
  task automatic reply(input string e);
    int n = 0;
    while (u_ascu_host.got.size() < e.len() && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    chk(u_ascu_host.got.size(), e.len());
    for (int i = 0; i < e.len() && i < u_ascu_host.got.size(); i++) begin
      chk(u_ascu_host.got[i], e[i]);
    end
    u_ascu_host.got.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    adr = 8'h00;
    wdat = 32'h0;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    pf_strobe = 1'b0;
    pf_stamp = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wb(`ASCU_OFF_CTRL, 1'b0, 32'h0);
    chk(q, `ASCU_CTRL_RST);
    wb(8'hFC, 1'b1, 32'hFFFF_FFFF);
    wb(8'hFC, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(`ASCU_OFF_FAULT, 1'b1, 32'h0000_0201);
    wb(`ASCU_OFF_GAS_HI, 1'b1, 32'h312E_3233);
    wb(`ASCU_OFF_GAS_LO, 1'b1, 32'h3435_3637);
    u_ascu_host.send({"DZ", "ERO,000\r"});
    reply("\x06");
    chk(mode, ascu_pkg::ASCU_MODE_ZERO);
    u_ascu_host.send({"DC", "ONC,000\r"});
    reply("1.234567 8052\r\n");
    u_ascu_host.slow = 1'b1;
    u_ascu_host.send({"DS", "PAN,000\r"});
    reply("\x06");
    chk(mode, ascu_pkg::ASCU_MODE_SPAN);
    wb(`ASCU_OFF_STATUS, 1'b0, 32'h0);
    chk(q[15:0], 16'h804A);
    u_ascu_host.send("ABORT,000\r");
    reply("\x06");
    chk(mode, ascu_pkg::ASCU_MODE_MEASURE);
    u_ascu_host.send({"DZ", "ERO,005\r"});
    reply("");
    wb(`ASCU_OFF_CTRL, 1'b1, 32'h0000_0020);
    u_ascu_host.send({"DS", "PAN,000\r"});
    reply("\x15");
    chk(mode, ascu_pkg::ASCU_MODE_MEASURE);
    wb(`ASCU_OFF_STATUS, 1'b0, 32'h0);
    chk(q[15:0], 16'h8060);
    wb(`ASCU_OFF_CTRL, 1'b1, 32'h0000_0009);
    chk(proto2, ascu_pkg::ASCU_PROTO_ADV);
    s = "";
    repeat (120) s = {s, "A"};
    u_ascu_host.frame("DA097", 8'h00);
    u_ascu_host.frame(s, 8'h00);
    u_ascu_host.frame("DA097", 8'h01);
    u_ascu_host.frame({s, "A"}, 8'h00);
    reply("");
    wb(`ASCU_OFF_STATUS, 1'b0, 32'h0);
    chk(q[31:16], 16'h0202);
    wb(`ASCU_OFF_CTRL, 1'b1, 32'h0000_0000);
    u_ascu_host.send("RESET,000\r");
    reply("\x06");
    chk(reboots, 1);
    @(posedge clk);
    pf_stamp <= {6'd24, 4'd7, 5'd15, 5'd13, 6'd45, 6'd30};
    pf_strobe <= 1'b1;
    @(posedge clk);
    pf_strobe <= 1'b0;
    wb(`ASCU_OFF_PFTIME, 1'b0, 32'h0);
    chk(q, {6'd24, 4'd7, 5'd15, 5'd13, 6'd45, 6'd30});
    wb(`ASCU_OFF_RANGE0, 1'b1, 32'h1234_0100);
    wb(`ASCU_OFF_RANGE2, 1'b1, 32'hABCD_0200);
    wb(`ASCU_OFF_OVR_EN, 1'b1, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk(fs, 48'h0200_0000_0100);
    wb(`ASCU_OFF_OVR_EN, 1'b1, 32'h0000_0005);
    repeat (3) @(posedge clk);
    chk(fs, 48'hABCD_0000_1234);
    print_verdict();
  end
endmodule
`default_nettype wire
